//--- core/lcsc_pkg.sv
// Constants and types shared by the logic cell storage and control block
package lcsc_pkg;
    localparam int ADDR_W = 6;
    localparam logic [5:0] ADDR_CTRL   = 6'h00;
    localparam logic [5:0] ADDR_CMAP   = 6'h04;
    localparam logic [5:0] ADDR_XCFG   = 6'h08;
    localparam logic [5:0] ADDR_YCFG   = 6'h0c;
    localparam logic [5:0] ADDR_FTAB   = 6'h10;
    localparam logic [5:0] ADDR_GTAB   = 6'h14;
    localparam logic [5:0] ADDR_HTAB   = 6'h18;
    localparam logic [5:0] ADDR_IOCFG  = 6'h1c;
    localparam logic [5:0] ADDR_STATUS = 6'h20;
    // Control register fields
    localparam int CTRL_MODE_LSB  = 0;
    localparam int CTRL_LEVEL_BIT = 2;
    // Element configuration fields
    localparam int ECFG_SRC_LSB   = 0;
    localparam int ECFG_SET_BIT   = 2;
    localparam int ECFG_SREN_BIT  = 3;
    localparam int ECFG_BYP_BIT   = 4;
    localparam int ECFG_BSEL_LSB  = 5;
    localparam int IOCFG_SET_BIT  = 0;
    // Reset values
    localparam logic [31:0] CTRL_RST  = 32'h0000_0000;
    localparam logic [31:0] CMAP_RST  = 32'h0000_00e4;
    localparam logic [31:0] ECFG_RST  = 32'h0000_0000;
    localparam logic [15:0] TAB_RST   = 16'h0000;
    localparam logic [7:0]  HTAB_RST  = 8'h00;
    localparam logic [1:0]  RESP_OKAY   = 2'b00;
    localparam logic [1:0]  RESP_SLVERR = 2'b10;
    // Internal control slots fed by the control mux
    localparam int SLOT_CE  = 0;
    localparam int SLOT_RS  = 1;
    localparam int SLOT_DIN = 2;
    localparam int SLOT_AUX = 3;
    typedef enum logic [1:0] {
        LCSC_LOGIC,
        LCSC_RAM16X2,
        LCSC_RAM32X1,
        LCSC_RAM16X1_DP
    } lcsc_mode_t;
    typedef enum logic [1:0] {
        LCSC_SRC_F,
        LCSC_SRC_G,
        LCSC_SRC_H,
        LCSC_SRC_DIRECT
    } lcsc_src_t;
endpackage

//--- core/lcsc_lut_ram.sv
// Look-up table storage of the first and second function generators
`timescale 1ns/1ps
module lcsc_lut_ram (
    input  wire logic        i_clk,
    input  wire logic        i_rst_n,
    input  wire logic        i_cfg_we_f,
    input  wire logic        i_cfg_we_g,
    input  wire logic [15:0] i_cfg_data,
    input  wire logic        i_wr_f,
    input  wire logic        i_wr_g,
    input  wire logic [3:0]  i_waddr,
    input  wire logic        i_wdata_f,
    input  wire logic        i_wdata_g,
    input  wire logic [3:0]  i_raddr_f,
    input  wire logic [3:0]  i_raddr_g,
    output logic             o_rd_f,
    output logic             o_rd_g,
    output logic [15:0]      o_tab_f,
    output logic [15:0]      o_tab_g
);
    logic [15:0] f_mem_q;
    logic [15:0] g_mem_q;

    // Configuration load wins over a fabric write in the same cycle
    always_ff @(posedge i_clk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            f_mem_q <= lcsc_pkg::TAB_RST;
        end else if (i_cfg_we_f) begin
            f_mem_q <= i_cfg_data;
        end else if (i_wr_f) begin
            f_mem_q[i_waddr] <= i_wdata_f;
        end
    end

    always_ff @(posedge i_clk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            g_mem_q <= lcsc_pkg::TAB_RST;
        end else if (i_cfg_we_g) begin
            g_mem_q <= i_cfg_data;
        end else if (i_wr_g) begin
            g_mem_q[i_waddr] <= i_wdata_g;
        end
    end

    always_ff @(posedge i_clk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            o_rd_f <= 1'b0;
            o_rd_g <= 1'b0;
        end else begin
            o_rd_f <= f_mem_q[i_raddr_f];
            o_rd_g <= g_mem_q[i_raddr_g];
        end
    end

    assign o_tab_f = f_mem_q;
    assign o_tab_g = g_mem_q;
endmodule

//--- core/lcsc_top.sv
// Storage elements, control mapping and table memory of one logic block
//
// The AXI4-Lite slave port and the address map were chosen for this implementation.
`timescale 1ns/1ps
module lcsc_top (
    input  wire logic        I_REF_CLK,
    input  wire logic        I_RSTN,
    input  wire logic [5:0]  I_AWADDR,
    input  wire logic        I_AWVALID,
    output logic             O_AWREADY,
    input  wire logic [31:0] I_WDATA,
    input  wire logic [3:0]  I_WSTRB,
    input  wire logic        I_WVALID,
    output logic             O_WREADY,
    output logic [1:0]       O_BRESP,
    output logic             O_BVALID,
    input  wire logic        I_BREADY,
    input  wire logic [5:0]  I_ARADDR,
    input  wire logic        I_ARVALID,
    output logic             O_ARREADY,
    output logic [31:0]      O_RDATA,
    output logic [1:0]       O_RRESP,
    output logic             O_RVALID,
    input  wire logic        I_RREADY,
    input  wire logic [3:0]  I_BLOCK_CONTROL_INPUTS,
    input  wire logic [3:0]  I_F_LUT_ADDR,
    input  wire logic [3:0]  I_G_LUT_ADDR,
    input  wire logic        I_GLOBAL_SETRESET_NET,
    input  wire logic        I_IO_FF_D,
    input  wire logic        I_IO_FF_CE,
    output logic             O_FIRST_REGISTERED_OUTPUT,
    output logic             O_SECOND_REGISTERED_OUTPUT,
    output logic             O_F_OUT,
    output logic             O_G_OUT,
    output logic             O_H_OUT,
    output logic             O_IO_FF_Q
);
    logic [31:0] ctrl_q;
    logic [31:0] cmap_q;
    logic [31:0] xcfg_q;
    logic [31:0] ycfg_q;
    logic [7:0]  htab_q;
    logic        io_set_q;
    logic [5:0]  awaddr_q;
    logic        aw_held_q;
    logic [31:0] wdata_q;
    logic [3:0]  wstrb_q;
    logic        w_held_q;
    logic        do_write;
    logic [31:0] wr_word;
    logic        cfg_pulse_q;
    logic        glr_s1_q;
    logic        glr_s2_q;
    logic        glr_s3_q;
    logic        glr_q;
    logic [3:0]  ictl;
    lcsc_pkg::lcsc_mode_t mode;
    logic        ram_mode;
    logic        storage_clock_enable;
    logic        local_async_setreset;
    logic        direct_data_in;
    logic        third_lut_input_zero;
    logic        third_lut_input_one;
    logic        third_lut_input_two;
    logic        ram_write_enable;
    logic        ram_data_low;
    logic        ram_data_high_or_addr4;
    logic        wr_en;
    logic        wr_f;
    logic        wr_g;
    logic        wdata_g;
    logic [3:0]  raddr_g;
    logic        addr4_q;
    logic        rd_f;
    logic        rd_g;
    logic [15:0] tab_f;
    logic [15:0] tab_g;
    logic        f_prime;
    logic        g_prime;
    logic        h_prime;
    logic        x_q;
    logic        y_q;
    logic        x_force;
    logic        y_force;
    logic        x_data;
    logic        y_data;
    logic        x_init;
    logic        y_init;

    // Byte-lane merge of a write into the current word
    function automatic logic [31:0] merge_strb(input logic [31:0] old,
                                               input logic [31:0] nw,
                                               input logic [3:0]  strb);
        logic [31:0] r;
        r = old;
        for (int i = 0; i < 4; i++) begin
            if (strb[i]) begin
                r[i*8 +: 8] = nw[i*8 +: 8];
            end
        end
        return r;
    endfunction

    // Data source selector of one element
    function automatic logic pick_src(input logic [1:0] sel,
                                      input logic f, input logic g,
                                      input logic h, input logic d);
        logic r;
        r = d;
        unique case (lcsc_pkg::lcsc_src_t'(sel))
            lcsc_pkg::LCSC_SRC_F:      r = f;
            lcsc_pkg::LCSC_SRC_G:      r = g;
            lcsc_pkg::LCSC_SRC_H:      r = h;
            lcsc_pkg::LCSC_SRC_DIRECT: r = d;
        endcase
        return r;
    endfunction

    // ---------------- AXI4-Lite slave ----------------
    assign O_AWREADY = !aw_held_q && !O_BVALID;
    assign O_WREADY  = !w_held_q && !O_BVALID;
    assign O_ARREADY = !O_RVALID;
    assign do_write  = aw_held_q && w_held_q && !O_BVALID;

    always_ff @(posedge I_REF_CLK or negedge I_RSTN) begin
        if (!I_RSTN) begin
            aw_held_q <= 1'b0;
            awaddr_q  <= 6'h00;
            w_held_q  <= 1'b0;
            wdata_q   <= 32'h0000_0000;
            wstrb_q   <= 4'h0;
        end else begin
            if (I_AWVALID && O_AWREADY) begin
                aw_held_q <= 1'b1;
                awaddr_q  <= I_AWADDR;
            end else if (do_write) begin
                aw_held_q <= 1'b0;
            end
            if (I_WVALID && O_WREADY) begin
                w_held_q <= 1'b1;
                wdata_q  <= I_WDATA;
                wstrb_q  <= I_WSTRB;
            end else if (do_write) begin
                w_held_q <= 1'b0;
            end
        end
    end

    always_ff @(posedge I_REF_CLK or negedge I_RSTN) begin
        if (!I_RSTN) begin
            O_BVALID <= 1'b0;
            O_BRESP  <= lcsc_pkg::RESP_OKAY;
        end else if (do_write) begin
            O_BVALID <= 1'b1;
            O_BRESP  <= (awaddr_q <= lcsc_pkg::ADDR_IOCFG &&
                         awaddr_q[1:0] == 2'b00) ?
                        lcsc_pkg::RESP_OKAY : lcsc_pkg::RESP_SLVERR;
        end else if (I_BREADY) begin
            O_BVALID <= 1'b0;
        end
    end

    always_ff @(posedge I_REF_CLK or negedge I_RSTN) begin
        if (!I_RSTN) begin
            ctrl_q   <= lcsc_pkg::CTRL_RST;
            cmap_q   <= lcsc_pkg::CMAP_RST;
            xcfg_q   <= lcsc_pkg::ECFG_RST;
            ycfg_q   <= lcsc_pkg::ECFG_RST;
            htab_q   <= lcsc_pkg::HTAB_RST;
            io_set_q <= 1'b0;
        end else if (do_write) begin
            unique case (awaddr_q)
                lcsc_pkg::ADDR_CTRL: ctrl_q <= wr_word;
                lcsc_pkg::ADDR_CMAP: cmap_q <= wr_word;
                lcsc_pkg::ADDR_XCFG: xcfg_q <= wr_word;
                lcsc_pkg::ADDR_YCFG: ycfg_q <= wr_word;
                lcsc_pkg::ADDR_HTAB: htab_q <= wr_word[7:0];
                lcsc_pkg::ADDR_IOCFG: begin
                    io_set_q <= wr_word[lcsc_pkg::IOCFG_SET_BIT];
                end
                default: ;
            endcase
        end
    end

    always_comb begin
        unique case (awaddr_q)
            lcsc_pkg::ADDR_CTRL:  wr_word = merge_strb(ctrl_q, wdata_q,
                                                       wstrb_q);
            lcsc_pkg::ADDR_CMAP:  wr_word = merge_strb(cmap_q, wdata_q,
                                                       wstrb_q);
            lcsc_pkg::ADDR_XCFG:  wr_word = merge_strb(xcfg_q, wdata_q,
                                                       wstrb_q);
            lcsc_pkg::ADDR_YCFG:  wr_word = merge_strb(ycfg_q, wdata_q,
                                                       wstrb_q);
            lcsc_pkg::ADDR_FTAB:  wr_word = merge_strb({16'h0000, tab_f},
                                                       wdata_q, wstrb_q);
            lcsc_pkg::ADDR_GTAB:  wr_word = merge_strb({16'h0000, tab_g},
                                                       wdata_q, wstrb_q);
            lcsc_pkg::ADDR_HTAB:  wr_word = merge_strb({24'h000000, htab_q},
                                                       wdata_q, wstrb_q);
            lcsc_pkg::ADDR_IOCFG: wr_word = merge_strb({31'h0, io_set_q},
                                                       wdata_q, wstrb_q);
            default:              wr_word = 32'h0000_0000;
        endcase
    end

    // A configuration reload acts like a global reset pulse
    always_ff @(posedge I_REF_CLK or negedge I_RSTN) begin
        if (!I_RSTN) begin
            cfg_pulse_q <= 1'b0;
        end else begin
            cfg_pulse_q <= do_write && (awaddr_q == lcsc_pkg::ADDR_XCFG ||
                           awaddr_q == lcsc_pkg::ADDR_YCFG ||
                           awaddr_q == lcsc_pkg::ADDR_IOCFG);
        end
    end

    always_ff @(posedge I_REF_CLK or negedge I_RSTN) begin
        if (!I_RSTN) begin
            O_RVALID <= 1'b0;
            O_RDATA  <= 32'h0000_0000;
            O_RRESP  <= lcsc_pkg::RESP_OKAY;
        end else if (I_ARVALID && O_ARREADY) begin
            O_RVALID <= 1'b1;
            O_RRESP  <= lcsc_pkg::RESP_OKAY;
            unique case (I_ARADDR)
                lcsc_pkg::ADDR_CTRL:  O_RDATA <= ctrl_q;
                lcsc_pkg::ADDR_CMAP:  O_RDATA <= cmap_q;
                lcsc_pkg::ADDR_XCFG:  O_RDATA <= xcfg_q;
                lcsc_pkg::ADDR_YCFG:  O_RDATA <= ycfg_q;
                lcsc_pkg::ADDR_FTAB:  O_RDATA <= {16'h0000, tab_f};
                lcsc_pkg::ADDR_GTAB:  O_RDATA <= {16'h0000, tab_g};
                lcsc_pkg::ADDR_HTAB:  O_RDATA <= {24'h000000, htab_q};
                lcsc_pkg::ADDR_IOCFG: O_RDATA <= {31'h0, io_set_q};
                lcsc_pkg::ADDR_STATUS: begin
                    O_RDATA <= {25'h0, h_prime, g_prime, f_prime,
                                O_IO_FF_Q, glr_q, y_q, x_q};
                end
                default: begin
                    O_RDATA <= 32'h0000_0000;
                    O_RRESP <= lcsc_pkg::RESP_SLVERR;
                end
            endcase
        end else if (I_RREADY) begin
            O_RVALID <= 1'b0;
        end
    end

    // ---------------- Global reset net ----------------
    // Pin level, so three stages; only a stable stage pair updates it
    always_ff @(posedge I_REF_CLK or negedge I_RSTN) begin
        if (!I_RSTN) begin
            glr_s1_q <= 1'b0;
            glr_s2_q <= 1'b0;
            glr_s3_q <= 1'b0;
            glr_q    <= 1'b0;
        end else begin
            glr_s1_q <= I_GLOBAL_SETRESET_NET;
            glr_s2_q <= glr_s1_q;
            glr_s3_q <= glr_s2_q;
            if (glr_s2_q == glr_s3_q) begin
                glr_q <= glr_s3_q;
            end
        end
    end

    // ---------------- Control mapping ----------------
    always_comb begin
        for (int s = 0; s < 4; s++) begin
            ictl[s] = I_BLOCK_CONTROL_INPUTS[cmap_q[s*2 +: 2]];
        end
    end

    assign mode     = lcsc_pkg::lcsc_mode_t'(ctrl_q[lcsc_pkg::CTRL_MODE_LSB
                                                    +: 2]);
    assign ram_mode = (mode != lcsc_pkg::LCSC_LOGIC);
    // Slot meaning depends on mode; memory mode steals set/reset
    assign storage_clock_enable   = ictl[lcsc_pkg::SLOT_CE];
    assign local_async_setreset   = !ram_mode && ictl[lcsc_pkg::SLOT_RS];
    assign third_lut_input_zero   = ictl[lcsc_pkg::SLOT_RS];
    assign direct_data_in         = ictl[lcsc_pkg::SLOT_DIN];
    assign third_lut_input_two    = ictl[lcsc_pkg::SLOT_DIN];
    assign third_lut_input_one    = ictl[lcsc_pkg::SLOT_AUX];
    assign ram_write_enable       = ram_mode && ictl[lcsc_pkg::SLOT_RS];
    assign ram_data_low           = ictl[lcsc_pkg::SLOT_DIN];
    assign ram_data_high_or_addr4 = ictl[lcsc_pkg::SLOT_AUX];

    // ---------------- Table memory ----------------
    // Level mode writes every cycle the write enable is high; edge mode also needs the enable
    assign wr_en = ram_write_enable &&
                   (ctrl_q[lcsc_pkg::CTRL_LEVEL_BIT] ||
                    storage_clock_enable);

    always_comb begin
        wr_f    = 1'b0;
        wr_g    = 1'b0;
        wdata_g = ram_data_low;
        raddr_g = I_F_LUT_ADDR;
        unique case (mode)
            lcsc_pkg::LCSC_LOGIC: begin
                raddr_g = I_G_LUT_ADDR;
            end
            lcsc_pkg::LCSC_RAM16X2: begin
                wr_f    = wr_en;
                wr_g    = wr_en;
                wdata_g = ram_data_high_or_addr4;
            end
            lcsc_pkg::LCSC_RAM32X1: begin
                wr_f = wr_en && !ram_data_high_or_addr4;
                wr_g = wr_en && ram_data_high_or_addr4;
            end
            lcsc_pkg::LCSC_RAM16X1_DP: begin
                wr_f    = wr_en;
                wr_g    = wr_en;
                raddr_g = I_G_LUT_ADDR;
            end
        endcase
    end

    always_ff @(posedge I_REF_CLK or negedge I_RSTN) begin
        if (!I_RSTN) begin
            addr4_q <= 1'b0;
        end else begin
            addr4_q <= ram_data_high_or_addr4;
        end
    end

    lcsc_lut_ram u_lut_ram (
        .i_clk      (I_REF_CLK),
        .i_rst_n    (I_RSTN),
        .i_cfg_we_f (do_write && awaddr_q == lcsc_pkg::ADDR_FTAB),
        .i_cfg_we_g (do_write && awaddr_q == lcsc_pkg::ADDR_GTAB),
        .i_cfg_data (wr_word[15:0]),
        .i_wr_f     (wr_f),
        .i_wr_g     (wr_g),
        .i_waddr    (I_F_LUT_ADDR),
        .i_wdata_f  (ram_data_low),
        .i_wdata_g  (wdata_g),
        .i_raddr_f  (I_F_LUT_ADDR),
        .i_raddr_g  (raddr_g),
        .o_rd_f     (rd_f),
        .o_rd_g     (rd_g),
        .o_tab_f    (tab_f),
        .o_tab_g    (tab_g)
    );

    assign f_prime = (mode == lcsc_pkg::LCSC_RAM32X1 && addr4_q) ?
                     rd_g : rd_f;
    assign g_prime = rd_g;
    assign h_prime = htab_q[{third_lut_input_two, third_lut_input_one,
                             third_lut_input_zero}];

    // ---------------- Storage elements ----------------
    assign x_init  = xcfg_q[lcsc_pkg::ECFG_SET_BIT];
    assign y_init  = ycfg_q[lcsc_pkg::ECFG_SET_BIT];
    // Same init bit serves local and global force
    assign x_force = glr_q || cfg_pulse_q ||
                     (xcfg_q[lcsc_pkg::ECFG_SREN_BIT] &&
                      local_async_setreset);
    assign y_force = glr_q || cfg_pulse_q ||
                     (ycfg_q[lcsc_pkg::ECFG_SREN_BIT] &&
                      local_async_setreset);
    assign x_data  = pick_src(xcfg_q[lcsc_pkg::ECFG_SRC_LSB +: 2], f_prime,
                              g_prime, h_prime, direct_data_in);
    assign y_data  = pick_src(ycfg_q[lcsc_pkg::ECFG_SRC_LSB +: 2], f_prime,
                              g_prime, h_prime, direct_data_in);

    // Forcing is sampled by the clock, so it takes hold one edge later
    always_ff @(posedge I_REF_CLK or negedge I_RSTN) begin
        if (!I_RSTN) begin
            x_q <= 1'b0;
        end else if (x_force) begin
            x_q <= x_init;
        end else if (storage_clock_enable) begin
            x_q <= x_data;
        end
    end

    always_ff @(posedge I_REF_CLK or negedge I_RSTN) begin
        if (!I_RSTN) begin
            y_q <= 1'b0;
        end else if (y_force) begin
            y_q <= y_init;
        end else if (storage_clock_enable) begin
            y_q <= y_data;
        end
    end

    always_ff @(posedge I_REF_CLK or negedge I_RSTN) begin
        if (!I_RSTN) begin
            O_IO_FF_Q <= 1'b0;
        end else if (glr_q || cfg_pulse_q) begin
            O_IO_FF_Q <= io_set_q;
        end else if (I_IO_FF_CE) begin
            O_IO_FF_Q <= I_IO_FF_D;
        end
    end

    // Bypass is a plain mux, kept combinational for the fast path
    assign O_FIRST_REGISTERED_OUTPUT  = xcfg_q[lcsc_pkg::ECFG_BYP_BIT] ?
        I_BLOCK_CONTROL_INPUTS[xcfg_q[lcsc_pkg::ECFG_BSEL_LSB +: 2]] :
        x_q;
    assign O_SECOND_REGISTERED_OUTPUT = ycfg_q[lcsc_pkg::ECFG_BYP_BIT] ?
        I_BLOCK_CONTROL_INPUTS[ycfg_q[lcsc_pkg::ECFG_BSEL_LSB +: 2]] :
        y_q;
    assign O_F_OUT = f_prime;
    assign O_G_OUT = g_prime;
    assign O_H_OUT = h_prime;
endmodule

//--- verif/lcsc_top_sva.sv
// Concurrent checks on the logic block ports
`timescale 1ns/1ps
module lcsc_top_sva (
    input wire logic I_REF_CLK,
    input wire logic I_RSTN,
    input wire logic I_AWVALID,
    input wire logic O_AWREADY,
    input wire logic I_WVALID,
    input wire logic O_WREADY,
    input wire logic O_BVALID,
    input wire logic I_ARVALID,
    input wire logic O_ARREADY,
    input wire logic O_RVALID,
    input wire logic I_GLOBAL_SETRESET_NET,
    input wire logic I_IO_FF_D,
    input wire logic I_IO_FF_CE,
    input wire logic O_FIRST_REGISTERED_OUTPUT,
    input wire logic O_SECOND_REGISTERED_OUTPUT,
    input wire logic O_IO_FF_Q
);
    default clocking cb @(posedge I_REF_CLK); endclocking
    default disable iff (!I_RSTN);
    // Config writes pulse the same force as the global net, so wait until all has settled
    logic [3:0] calm_q;
    always_ff @(posedge I_REF_CLK or negedge I_RSTN) begin
        if (!I_RSTN) calm_q <= 4'h0;
        else if (I_GLOBAL_SETRESET_NET || I_AWVALID || !O_AWREADY)
            calm_q <= 4'h0;
        else if (calm_q != 4'hf) calm_q <= calm_q + 4'h1;
    end
    a_io_hold: assert property (
        calm_q > 4'h5 && !I_IO_FF_CE |=> $stable(O_IO_FF_Q))
        else $error("io flop moved while disabled");
    a_io_load: assert property (
        calm_q > 4'h5 && I_IO_FF_CE |=> O_IO_FF_Q == $past(I_IO_FF_D))
        else $error("io flop missed its data");
    a_glb_io: assert property (
        I_GLOBAL_SETRESET_NET [*6] |=> $stable(O_IO_FF_Q))
        else $error("io flop moved under global reset");
    a_glb_first: assert property (
        I_GLOBAL_SETRESET_NET [*6] |=> $stable(O_FIRST_REGISTERED_OUTPUT))
        else $error("first output moved under global reset");
    a_glb_second: assert property (
        I_GLOBAL_SETRESET_NET [*6] |=> $stable(O_SECOND_REGISTERED_OUTPUT))
        else $error("second output moved under global reset");
    a_aw_blocked: assert property (O_BVALID |-> !O_AWREADY)
        else $error("write address ready during response");
    a_ar_blocked: assert property (O_RVALID |-> !O_ARREADY)
        else $error("read address ready during read data");
    a_read_answer: assert property (I_ARVALID && O_ARREADY |=> O_RVALID)
        else $error("read data late");
    a_write_answer: assert property (I_AWVALID && O_AWREADY && I_WVALID
        && O_WREADY |-> ##[1:2] O_BVALID)
        else $error("write response late");
endmodule
bind lcsc_top lcsc_top_sva u_sva (.I_REF_CLK, .I_RSTN, .I_AWVALID, .O_AWREADY,
    .I_WVALID, .O_WREADY, .O_BVALID, .I_ARVALID, .O_ARREADY, .O_RVALID,
    .I_GLOBAL_SETRESET_NET, .I_IO_FF_D, .I_IO_FF_CE, .O_FIRST_REGISTERED_OUTPUT,
    .O_SECOND_REGISTERED_OUTPUT, .O_IO_FF_Q);

//--- verif/lcsc_fabric_model.sv
// User logic that drives the global reset net from a pin or a node
`timescale 1ns/1ps
module lcsc_fabric_model (
    input  wire logic i_clk,
    input  wire logic i_pin,
    input  wire logic i_pin_inv,
    input  wire logic i_node,
    input  wire logic i_use_node,
    output logic      o_gsr
);
    // Registered so the net only moves just after a clock edge
    always_ff @(posedge i_clk) begin
        if (i_use_node) o_gsr <= i_node;
        else o_gsr <= i_pin ^ i_pin_inv;
    end
endmodule

//--- verif/lcsc_tb_top.sv
// Self-checking bench for the logic block storage and control
`timescale 1ns/1ps
module lcsc_tb_top;
    logic        I_REF_CLK, I_RSTN, I_AWVALID, I_WVALID, I_BREADY, I_ARVALID;
    logic        I_RREADY, I_IO_FF_D, I_IO_FF_CE, O_AWREADY, O_WREADY;
    logic        O_BVALID, O_ARREADY, O_RVALID, O_F_OUT, O_G_OUT, O_H_OUT;
    logic        O_FIRST_REGISTERED_OUTPUT, O_SECOND_REGISTERED_OUTPUT;
    logic        O_IO_FF_Q, I_GLOBAL_SETRESET_NET, pin, pin_inv, node, use_n;
    logic [5:0]  I_AWADDR, I_ARADDR;
    logic [31:0] I_WDATA, O_RDATA;
    logic [1:0]  O_BRESP, O_RRESP;
    logic [3:0]  I_BLOCK_CONTROL_INPUTS;
    int          err_total, samples_checked;
    wire logic [3:0] vis = {O_FIRST_REGISTERED_OUTPUT,
        O_SECOND_REGISTERED_OUTPUT, O_IO_FF_Q, O_H_OUT};
    lcsc_top u_dut (.I_REF_CLK, .I_RSTN, .I_AWADDR, .I_AWVALID, .O_AWREADY,
        .I_WDATA, .I_WSTRB(4'hf), .I_WVALID, .O_WREADY, .O_BRESP, .O_BVALID,
        .I_BREADY, .I_ARADDR, .I_ARVALID, .O_ARREADY, .O_RDATA, .O_RRESP,
        .O_RVALID, .I_RREADY, .I_BLOCK_CONTROL_INPUTS, .I_F_LUT_ADDR(4'h0),
        .I_G_LUT_ADDR(4'h0), .I_GLOBAL_SETRESET_NET, .I_IO_FF_D, .I_IO_FF_CE,
        .O_FIRST_REGISTERED_OUTPUT, .O_SECOND_REGISTERED_OUTPUT, .O_F_OUT,
        .O_G_OUT, .O_H_OUT, .O_IO_FF_Q);
    lcsc_fabric_model u_fab (.i_clk(I_REF_CLK), .i_pin(pin), .i_node(node),
        .i_pin_inv(pin_inv), .i_use_node(use_n), .o_gsr(I_GLOBAL_SETRESET_NET));
    initial begin
        I_REF_CLK = 1'b0;
        forever #5 I_REF_CLK = ~I_REF_CLK;
    end
    task automatic conclude();
        if (err_total == 0 && samples_checked > 0)
            $display("DONE - PASS");
        else
            $display("DONE - FAIL");
        $finish;
    endtask
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        samples_checked++;
        if (got !== exp) begin
            err_total++;
            $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask
    task automatic limit(input logic ok);
        if (!ok) begin
            err_total++;
            conclude();
        end
    endtask
    task automatic cyc(input int n);
        repeat (n) @(posedge I_REF_CLK);
    endtask
    task automatic wr(input logic [5:0] a, input logic [31:0] d);
        logic ra, rw, rb;
        I_AWADDR <= a;
        I_WDATA <= d;
        {I_AWVALID, I_WVALID, I_BREADY} <= 3'h7;
        rb = 1'b0;
        for (int n = 0; n < 40 && !rb; n++) begin
            @(negedge I_REF_CLK);
            {ra, rw, rb} = {O_AWREADY, O_WREADY, O_BVALID};
            @(posedge I_REF_CLK);
            if (ra) I_AWVALID <= 1'b0;
            if (rw) I_WVALID <= 1'b0;
        end
        limit(rb);
        I_BREADY <= 1'b0;
        chk({30'h0, O_BRESP}, {30'h0, lcsc_pkg::RESP_OKAY});
        @(posedge I_REF_CLK);
    endtask
    task automatic rd(input logic [5:0] a, input logic [31:0] e,
                      input logic [1:0] er);
        logic ra, rv;
        logic [33:0] got;
        I_ARADDR <= a;
        {I_ARVALID, I_RREADY} <= 2'h3;
        rv = 1'b0;
        for (int n = 0; n < 40 && !rv; n++) begin
            @(negedge I_REF_CLK);
            {ra, rv, got} = {O_ARREADY, O_RVALID, O_RRESP, O_RDATA};
            @(posedge I_REF_CLK);
            if (ra) I_ARVALID <= 1'b0;
        end
        limit(rv);
        I_RREADY <= 1'b0;
        chk(got[31:0], e);
        chk({30'h0, got[33:32]}, {30'h0, er});
        @(posedge I_REF_CLK);
    endtask
    task automatic step(input logic [3:0] c, input logic [3:0] e);
        I_BLOCK_CONTROL_INPUTS <= c;
        @(posedge I_REF_CLK);
        @(negedge I_REF_CLK);
        chk({28'h0, vis}, {28'h0, e});
        @(posedge I_REF_CLK);
    endtask
    task automatic s_regs();
        rd(lcsc_pkg::ADDR_CMAP, lcsc_pkg::CMAP_RST, lcsc_pkg::RESP_OKAY);
        rd(lcsc_pkg::ADDR_XCFG, lcsc_pkg::ECFG_RST, lcsc_pkg::RESP_OKAY);
        rd(6'h24, 32'h0, lcsc_pkg::RESP_SLVERR);
    endtask
    task automatic s_local();
        wr(lcsc_pkg::ADDR_XCFG, 32'h0f);
        wr(lcsc_pkg::ADDR_YCFG, 32'h0b);
        cyc(4);
        step(4'h0, 4'h8);
        step(4'h1, 4'h0);
        step(4'h4, 4'h0);
        step(4'h5, 4'hc);
        step(4'h2, 4'h8);
        step(4'h7, 4'h8);
        step(4'h5, 4'hc);
        wr(lcsc_pkg::ADDR_YCFG, 32'h03);
        cyc(4);
        step(4'h5, 4'hc);
        step(4'h2, 4'hc);
    endtask
    task automatic s_global();
        wr(lcsc_pkg::ADDR_IOCFG, 32'h1);
        cyc(4);
        {I_IO_FF_D, I_IO_FF_CE} <= 2'h1;
        step(4'h1, 4'h0);
        {I_IO_FF_CE, pin_inv} <= 2'h1;
        cyc(6);
        step(4'h0, 4'ha);
        pin_inv <= 1'b0;
        cyc(6);
        step(4'h5, 4'he);
        {use_n, node} <= 2'h3;
        cyc(6);
        step(4'h5, 4'ha);
        node <= 1'b0;
        cyc(6);
    endtask
    task automatic s_map();
        wr(lcsc_pkg::ADDR_CMAP, 32'h27);
        step(4'h8, 4'h2);
        step(4'h5, 4'h2);
        step(4'hc, 4'he);
        wr(lcsc_pkg::ADDR_CMAP, lcsc_pkg::CMAP_RST);
    endtask
    task automatic s_bypass();
        wr(lcsc_pkg::ADDR_XCFG, 32'h7f);
        wr(lcsc_pkg::ADDR_HTAB, 32'h80);
        cyc(4);
        step(4'h8, 4'ha);
        step(4'he, 4'hb);
        step(4'h6, 4'h2);
    endtask
    task automatic s_ram();
        wr(lcsc_pkg::ADDR_CTRL, 32'h1);
        step(4'h7, 4'h6);
        rd(lcsc_pkg::ADDR_FTAB, 32'h1, lcsc_pkg::RESP_OKAY);
        rd(lcsc_pkg::ADDR_GTAB, 32'h0, lcsc_pkg::RESP_OKAY);
        chk({30'h0, O_F_OUT, O_G_OUT}, 32'h2);
        wr(lcsc_pkg::ADDR_CTRL, 32'h2);
        step(4'hf, 4'hf);
        rd(lcsc_pkg::ADDR_GTAB, 32'h1, lcsc_pkg::RESP_OKAY);
        wr(lcsc_pkg::ADDR_CTRL, 32'h7);
        step(4'h2, 4'h6);
        rd(lcsc_pkg::ADDR_FTAB, 32'h0, lcsc_pkg::RESP_OKAY);
    endtask
    initial begin
        {err_total, samples_checked} = '0;
        {I_RSTN, I_AWVALID, I_WVALID, I_BREADY, I_ARVALID, I_RREADY} = '0;
        {I_IO_FF_D, I_IO_FF_CE, pin, pin_inv, node, use_n} = '0;
        {I_AWADDR, I_ARADDR, I_WDATA, I_BLOCK_CONTROL_INPUTS} = '0;
        cyc(5);
        I_RSTN <= 1'b1;
        s_regs();
        s_local();
        s_global();
        s_map();
        s_bypass();
        s_ram();
        conclude();
    end
endmodule
